// ---- acc_cal_regs.sv ----
// Calibration control register bank with a small calibration sequencer.
// Assumes an Avalon-MM master on clk_sys_i and alarm_i from the same clock.
//
// Notes on behaviour
// - Foreground run resets values, then calibrates.
// - Background enable bit gates background calibration.
// - Foreground offset only with foreground run.
// - Background offset needs background enable too.
// - Reference zero calibrates offsets to mid-code.
// - Reference one matches primaries to spare.
// - Offset averaging field sets offset step length.
// - Linearity averaging field sets linearity step length.
// - Status register is read only.
// - Halted flag sets when background stops.
// - Halted flag clears when calibration resumes.
// - Without background, halted sets after foreground.
// - Foreground done flag set after finish or skip.
// - Run enable low holds calibration in reset.
// - Selector zero routes done flag to pin.
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"

module acc_cal_regs
(
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  input  wire logic               ce_i,
  input  wire logic [9:0]         address_i,
  input  wire logic               read_i,
  input  wire logic               write_i,
  input  wire logic [31:0]        writedata_i,
  output logic      [31:0]        readdata_o,
  output logic                    waitrequest_o,
  input  wire logic               alarm_i,
  output logic                    irq_o,
  output logic                    calibration_status_pin_o,
  output logic                    cal_values_reset_o,
  output logic                    fg_lin_active_o,
  output logic                    fg_os_active_o,
  output logic                    bg_cal_active_o,
  output logic                    bg_os_active_o,
  output logic                    os_ref_spare_o,
  output logic [2:0]              offset_averaging_level_o,
  output logic [2:0]              linearity_averaging_level_o,
  output acc_pkg::acc_state_type  cal_state_o
);
  import acc_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  acc_byte_type  run_ctrl_r;
  acc_byte_type  mode_cfg_r;
  acc_byte_type  offset_reference_select_cfg_r;
  acc_byte_type  avg_cfg_r;
  acc_byte_type  irq_stat_r;
  acc_byte_type  irq_mask_r;
  acc_byte_type  status_byte;
  acc_byte_type  rd_nxt;
  acc_state_type state_r;
  acc_state_type state_nxt;
  logic          ack_r;
  logic          req;
  logic          wr_go;
  logic          foreground_complete_flag_r;
  logic          halted_r;
  logic          foreground_complete_flag_q;
  logic          halted_q;
  logic [7:0]    idx;
  logic [11:0]   step_cnt_r;
  logic          step_end;
  logic          run_en;
  logic          bg_stop;
  logic          bg_en;
  logic          fg_run;
  logic [1:0]    pin_sel;

  assign req           = read_i | write_i;
  // One wait cycle; the answer edge is the cycle after the request rises
  assign waitrequest_o = req & ~ack_r;
  assign wr_go         = write_i & ack_r & ce_i;
  assign idx           = address_i[9:2];

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      ack_r <= 1'b0;
    else if (ce_i)
      ack_r <= req & ~ack_r;
  end

  assign status_byte = {3'h0, state_r, halted_r, foreground_complete_flag_r};

  always_comb
  begin
    rd_nxt = 8'h00;
    if (address_i[1:0] == 2'h0)
    begin
      case (idx)
        `ACC_IDX_RUN_CTRL:  rd_nxt = run_ctrl_r;
        `ACC_IDX_MODE_CFG:  rd_nxt = mode_cfg_r;
        `ACC_IDX_OFFSET_REFERENCE_SELECT_CFG: rd_nxt = offset_reference_select_cfg_r;
        `ACC_IDX_AVG_CFG:   rd_nxt = avg_cfg_r;
        `ACC_IDX_STATUS:    rd_nxt = status_byte;
        `ACC_IDX_IRQ_STAT:  rd_nxt = irq_stat_r;
        `ACC_IDX_IRQ_MASK:  rd_nxt = irq_mask_r;
        default:            rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      readdata_o <= 32'h0000_0000;
    else if (ce_i && read_i && !ack_r)
      readdata_o <= {24'h00_0000, rd_nxt};
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Reserved bits are stored as written; software keeps them at reset value
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      run_ctrl_r  <= `ACC_RST_RUN_CTRL;
      mode_cfg_r  <= `ACC_RST_MODE_CFG;
      offset_reference_select_cfg_r <= `ACC_RST_OFFSET_REFERENCE_SELECT_CFG;
      avg_cfg_r   <= `ACC_RST_AVG_CFG;
      irq_mask_r  <= 8'h00;
    end
    else if (wr_go && address_i[1:0] == 2'h0)
    begin
      case (idx)
        `ACC_IDX_RUN_CTRL:  run_ctrl_r  <= writedata_i[7:0];
        `ACC_IDX_MODE_CFG:  mode_cfg_r  <= writedata_i[7:0];
        `ACC_IDX_OFFSET_REFERENCE_SELECT_CFG: offset_reference_select_cfg_r <= writedata_i[7:0];
        `ACC_IDX_AVG_CFG:   avg_cfg_r   <= writedata_i[7:0];
        `ACC_IDX_IRQ_MASK:  irq_mask_r  <= writedata_i[7:0];
        default:            irq_mask_r  <= irq_mask_r;
      endcase
    end
  end

  assign run_en  = run_ctrl_r[`ACC_B_RUN_EN];
  assign bg_stop = run_ctrl_r[`ACC_B_BG_STOP];
  assign pin_sel = run_ctrl_r[`ACC_B_PSEL_HI:`ACC_B_PSEL_LO];
  assign bg_en   = mode_cfg_r[`ACC_B_BG_EN];
  assign fg_run  = mode_cfg_r[`ACC_B_FG_RUN];

  // ****************************************
  // Calibration sequencer
  // ****************************************
  // offset or linearity averaging scales step
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      step_cnt_r <= 12'h000;
    else if (ce_i)
    begin
      if (state_r != state_nxt)
      begin
        if (state_nxt == ACC_FGOS)
          step_cnt_r <= `ACC_STEP_CYCLES << avg_cfg_r[`ACC_B_OAVG_HI:`ACC_B_OAVG_LO];
        else
          step_cnt_r <= `ACC_STEP_CYCLES << avg_cfg_r[`ACC_B_LAVG_HI:`ACC_B_LAVG_LO];
      end
      else if (step_cnt_r != 12'h000)
        step_cnt_r <= step_cnt_r - 12'h001;
    end
  end

  assign step_end = (step_cnt_r == 12'h001);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ACC_HOLD:
        if (run_en)
          state_nxt = ACC_CLEAR;
      ACC_CLEAR:
        if (fg_run)
          state_nxt = ACC_FGLIN;
        else if (bg_en)
          state_nxt = ACC_BGRUN;
        else
          state_nxt = ACC_DONE;
      ACC_FGLIN:
        if (step_end)
        begin
          if (mode_cfg_r[`ACC_B_FG_OS])
            state_nxt = ACC_FGOS;
          else if (bg_en)
            state_nxt = ACC_BGRUN;
          else
            state_nxt = ACC_DONE;
        end
      ACC_FGOS:
        if (step_end)
          state_nxt = bg_en ? ACC_BGRUN : ACC_DONE;
      ACC_BGRUN:
        if (!bg_en)
          state_nxt = ACC_DONE;
        else if (bg_stop)
          state_nxt = ACC_HALT;
      ACC_HALT:
        if (!bg_stop && bg_en)
          state_nxt = ACC_BGRUN;
        else if (!bg_en)
          state_nxt = ACC_DONE;
      ACC_DONE:
        if (bg_en)
          state_nxt = ACC_BGRUN;
      default:
        state_nxt = ACC_HOLD;
    endcase
    if (!run_en)
      state_nxt = ACC_HOLD;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      state_r <= ACC_HOLD;
    else if (ce_i)
      state_r <= state_nxt;
  end

  // ****************************************
  // Completion flags
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      foreground_complete_flag_r <= 1'b0;
      halted_r  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state_nxt == ACC_HOLD || state_nxt == ACC_CLEAR)
      begin
        foreground_complete_flag_r <= 1'b0;
        halted_r  <= 1'b0;
      end
      else
      begin
        if (state_nxt == ACC_BGRUN || state_nxt == ACC_DONE)
          foreground_complete_flag_r <= 1'b1;
        if (state_nxt == ACC_HALT || state_nxt == ACC_DONE)
          halted_r <= 1'b1;
        else if (state_nxt == ACC_BGRUN)
          halted_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      foreground_complete_flag_q  <= 1'b0;
      halted_q   <= 1'b0;
      irq_stat_r <= 8'h00;
    end
    else if (ce_i)
    begin
      foreground_complete_flag_q <= foreground_complete_flag_r;
      halted_q  <= halted_r;
      // Set beats a same-cycle write-one clear
      irq_stat_r <= (irq_stat_r &
                     ~((wr_go && idx == `ACC_IDX_IRQ_STAT && address_i[1:0] == 2'h0)
                       ? writedata_i[7:0] : 8'h00))
                    | {6'h00, halted_r & ~halted_q, foreground_complete_flag_r & ~foreground_complete_flag_q};
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ****************************************
  // Engine outputs
  // ****************************************
  // pin selector routing
  always_comb
  begin
    case (pin_sel)
      `ACC_PSEL_FOREGROUND_COMPLETE_FLAG: calibration_status_pin_o = foreground_complete_flag_r;
      `ACC_PSEL_HALTED:  calibration_status_pin_o = halted_r;
      `ACC_PSEL_ALARM:   calibration_status_pin_o = alarm_i;
      default:           calibration_status_pin_o = 1'b0;
    endcase
  end

  assign cal_values_reset_o = (state_r == ACC_CLEAR);
  assign fg_lin_active_o    = (state_r == ACC_FGLIN);
  assign fg_os_active_o     = (state_r == ACC_FGOS);
  assign bg_cal_active_o    = (state_r == ACC_BGRUN);
  assign bg_os_active_o     = (state_r == ACC_BGRUN) & mode_cfg_r[`ACC_B_BG_OS];
  assign os_ref_spare_o     = offset_reference_select_cfg_r[`ACC_B_OFFSET_REFERENCE_SELECT];
  assign offset_averaging_level_o    = avg_cfg_r[`ACC_B_OAVG_HI:`ACC_B_OAVG_LO];
  assign linearity_averaging_level_o = avg_cfg_r[`ACC_B_LAVG_HI:`ACC_B_LAVG_LO];
  assign cal_state_o        = state_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking acc_cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_clear_with_fg;
    ce_i && state_r == ACC_CLEAR && run_en && fg_run;
  endsequence

  sequence s_fg_started;
    state_r == ACC_FGLIN && fg_lin_active_o;
  endsequence

  a_fg_after_clear: assert property (
    s_clear_with_fg |=> s_fg_started)
    else $error("foreground did not follow clear");

  a_bg_needs_en: assert property (
    bg_cal_active_o |-> $past(bg_en))
    else $error("background active while disabled");

  a_fgos_needs_fg: assert property (
    (state_r == ACC_FGOS) |-> $past(state_r == ACC_FGOS || state_r == ACC_FGLIN))
    else $error("offset step without foreground run");

  a_bgos_gated: assert property (
    bg_os_active_o |-> $past(bg_en) && mode_cfg_r[`ACC_B_BG_OS])
    else $error("background offset without background");

  a_hold_clears: assert property (
    (ce_i && !run_en) |=> state_r == ACC_HOLD && !foreground_complete_flag_r)
    else $error("hold did not reset calibration");

  a_flags_cleared: assert property (
    (state_r == ACC_HOLD) |-> !foreground_complete_flag_r && !halted_r)
    else $error("flags set while held");

  a_halt_sets: assert property (
    (state_r == ACC_HALT) |-> halted_r && foreground_complete_flag_r)
    else $error("halted flag low in halt");

  a_resume_clears: assert property (
    (ce_i && state_r == ACC_HALT && run_en && bg_en && !bg_stop) |=> !halted_r)
    else $error("halted flag stuck on resume");

  a_nobg_halted: assert property (
    (state_r == ACC_DONE) |-> halted_r && foreground_complete_flag_r)
    else $error("halted flag low after foreground");

  a_pin_follow: assert property (
    (pin_sel == `ACC_PSEL_FOREGROUND_COMPLETE_FLAG) |-> calibration_status_pin_o == foreground_complete_flag_r)
    else $error("status pin not following done flag");

  a_bus_answer: assert property (
    (read_i && !ack_r && ce_i) ##1 read_i |-> !waitrequest_o)
    else $error("bus answer late");

endmodule
`default_nettype wire

// ---- acc_params.svh ----
// Constants for the calibration control register bank.
// Assumes inclusion by the package and the design file only.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register indices; byte address is four times the index
`define ACC_IDX_RUN_CTRL   8'h61
`define ACC_IDX_MODE_CFG   8'h62
`define ACC_IDX_OFFSET_REFERENCE_SELECT_CFG  8'h65
`define ACC_IDX_AVG_CFG    8'h68
`define ACC_IDX_STATUS     8'h6a
`define ACC_IDX_IRQ_STAT   8'h70
`define ACC_IDX_IRQ_MASK   8'h71

// Reset values
`define ACC_RST_RUN_CTRL   8'h01
`define ACC_RST_MODE_CFG   8'h01
`define ACC_RST_OFFSET_REFERENCE_SELECT_CFG  8'h01
`define ACC_RST_AVG_CFG    8'h61

// Field positions
`define ACC_B_RUN_EN       0
`define ACC_B_BG_STOP      1
`define ACC_B_PSEL_LO      2
`define ACC_B_PSEL_HI      3
`define ACC_B_FG_RUN       0
`define ACC_B_BG_EN        1
`define ACC_B_FG_OS        2
`define ACC_B_BG_OS        3
`define ACC_B_OFFSET_REFERENCE_SELECT        2
`define ACC_B_LAVG_LO      0
`define ACC_B_LAVG_HI      2
`define ACC_B_OAVG_LO      4
`define ACC_B_OAVG_HI      6
`define ACC_B_FOREGROUND_COMPLETE_FLAG      0
`define ACC_B_HALTED       1

// Pin selector codes
`define ACC_PSEL_FOREGROUND_COMPLETE_FLAG   2'h0
`define ACC_PSEL_HALTED    2'h1
`define ACC_PSEL_ALARM     2'h2

// Base length of one averaging step, in clock cycles
`define ACC_STEP_CYCLES    12'h010

`endif

// ---- acc_pkg.sv ----
// Types for the calibration control register bank.
// Assumes acc_params.svh sits in the same folder.
`include "acc_params.svh"

package acc_pkg;

  typedef logic [7:0] acc_byte_type;

  // Gray code along hold, clear, linearity, offset, background
  typedef enum logic [2:0]
  {
    ACC_HOLD  = 3'h0,
    ACC_CLEAR = 3'h1,
    ACC_FGLIN = 3'h3,
    ACC_FGOS  = 3'h2,
    ACC_BGRUN = 3'h6,
    ACC_HALT  = 3'h7,
    ACC_DONE  = 3'h5
  } acc_state_type;

endpackage

// ---- tb_acc_cal_regs.sv ----
// Self-checking bench for the calibration control register bank.
// Assumes acc_pkg and acc_cal_regs are compiled first; one clock at 50 MHz.
`timescale 1ns/1ps
`default_nettype none

module tb_acc_cal_regs;
  import acc_pkg::*;

  logic               clk_sys_i;
  logic               resetn_i;
  logic               ce_i;
  logic [9:0]         address_i;
  logic               read_i;
  logic               write_i;
  logic [31:0]        writedata_i;
  logic [31:0]        readdata_o;
  logic               waitrequest_o;
  logic               alarm_i;
  logic               irq_o;
  logic               pin_o;
  logic               clr_o;
  logic               lin_o;
  logic               os_o;
  logic               bg_o;
  logic               bgos_o;
  logic               spare_o;
  logic [2:0]         oavg_o;
  logic [2:0]         lavg_o;
  acc_state_type      state_o;
  int                 n_fail;
  int                 check_count;
  int                 lin_cnt;
  int                 os_cnt;
  int                 clr_cnt;
  int                 lin0;
  int                 os0;
  int                 clr0;

  acc_cal_regs acc_cal_regs_inst
  (
    .clk_sys_i                   (clk_sys_i),
    .resetn_i                    (resetn_i),
    .ce_i                        (ce_i),
    .address_i                   (address_i),
    .read_i                      (read_i),
    .write_i                     (write_i),
    .writedata_i                 (writedata_i),
    .readdata_o                  (readdata_o),
    .waitrequest_o               (waitrequest_o),
    .alarm_i                     (alarm_i),
    .irq_o                       (irq_o),
    .calibration_status_pin_o    (pin_o),
    .cal_values_reset_o          (clr_o),
    .fg_lin_active_o             (lin_o),
    .fg_os_active_o              (os_o),
    .bg_cal_active_o             (bg_o),
    .bg_os_active_o              (bgos_o),
    .os_ref_spare_o              (spare_o),
    .offset_averaging_level_o    (oavg_o),
    .linearity_averaging_level_o (lavg_o),
    .cal_state_o                 (state_o)
  );

  // ****************************************
  // Clock and phase counters
  // ****************************************
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
  begin
    if (lin_o === 1'b1) lin_cnt++;
    if (os_o === 1'b1) os_cnt++;
    if (clr_o === 1'b1) clr_cnt++;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    read_i      <= ~is_wr;
    write_i     <= is_wr;
    address_i   <= {idx, 2'b00};
    writedata_i <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (waitrequest_o !== 1'b0 && n < 50);
    if (waitrequest_o !== 1'b0) chk(8'h00, 8'hff);
    q = readdata_o[7:0];
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
    // Written value reaches the outputs only after the edge
    @(negedge clk_sys_i);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wait_state(input acc_state_type s);
    int n;
    n = 0;
    while (state_o !== s && n < 3000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk({5'h00, state_o}, {5'h00, s});
  endtask

  // Run enable low then high, with status cleared while held
  task automatic restart(input logic [7:0] rc, input logic [7:0] mode);
    wr(8'h62, mode);
    wr(8'h61, rc & 8'hfe);                  // hold calibration in reset
    rd_chk(8'h6a, 8'h00);                   // flags cleared in hold
    lin0 = lin_cnt;
    os0  = os_cnt;
    clr0 = clr_cnt;
    wr(8'h61, rc);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk({5'h00, oavg_o}, 8'h06);            // offset averaging default
    chk({5'h00, lavg_o}, 8'h01);            // linearity averaging default
    rd_chk(8'h62, 8'h01);                   // foreground run default
    rd_chk(8'h65, 8'h01);                   // reference default zero
    rd_chk(8'h68, 8'h61);                   // averaging default
    rd_chk(8'h71, 8'h00);
    wr(8'h63, 8'hff);
    rd_chk(8'h63, 8'h00);
    wait_state(ACC_DONE);
    wr(8'h6a, 8'hff);
    rd_chk(8'h6a, 8'h17);                   // status ignores writes
  endtask

  task automatic t_fg(input logic [7:0] avg, input int len);
    wr(8'h68, avg);                         // reserved bits kept zero
    restart(8'h01, 8'h05);
    wait_state(ACC_DONE);
    chk(8'(lin_cnt - lin0), 8'(len));       // linearity step length
    chk(8'(os_cnt - os0), 8'(len));         // offset step runs
    chk(8'(clr_cnt - clr0), 8'h01);         // values reset once
    rd_chk(8'h6a, 8'h17);                   // done and halted set
    chk({7'h00, pin_o}, 8'h01);             // pin follows done flag
  endtask

  task automatic t_skip_irq();
    wr(8'h70, 8'h03);
    chk({7'h00, irq_o}, 8'h00);
    restart(8'h01, 8'h04);
    wait_state(ACC_DONE);
    chk(8'(lin_cnt - lin0), 8'h00);         // foreground skipped
    chk(8'(os_cnt - os0), 8'h00);           // offset needs foreground run
    chk(8'(clr_cnt - clr0), 8'h01);         // values still reset
    rd_chk(8'h6a, 8'h17);                   // halted after skip
    chk({7'h00, irq_o}, 8'h00);
    wr(8'h71, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(8'h70, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    rd_chk(8'h70, 8'h02);
    wr(8'h71, 8'h02);
    chk({7'h00, irq_o}, 8'h01);
    wr(8'h70, 8'h02);
    chk({7'h00, irq_o}, 8'h00);
  endtask

  task automatic t_bg();
    restart(8'h01, 8'h0b);
    wait_state(ACC_BGRUN);
    rd_chk(8'h6a, 8'h19);                   // background runs, not halted
    chk({6'h00, bg_o, bgos_o}, 8'h03);      // background offset active
    wr(8'h65, 8'h05);                       // spare select drives spare_o in any state
    chk({7'h00, spare_o}, 8'h01);           // spare reference selected
    wr(8'h61, 8'h07);
    wait_state(ACC_HALT);
    rd_chk(8'h6a, 8'h1f);                   // halted after stop
    chk({7'h00, pin_o}, 8'h01);             // pin follows halted flag
    wr(8'h61, 8'h09);
    wait_state(ACC_BGRUN);
    rd_chk(8'h6a, 8'h19);                   // halted clears on resume
    alarm_i <= 1'b1;
    @(negedge clk_sys_i);
    chk({7'h00, pin_o}, 8'h01);             // pin follows alarm
    wr(8'h61, 8'h0d);
    chk({7'h00, pin_o}, 8'h00);             // pin held low
    alarm_i <= 1'b0;
    wr(8'h65, 8'h01);
    chk({7'h00, spare_o}, 8'h00);           // mid-code reference
    wr(8'h62, 8'h01);
    wait_state(ACC_DONE);                   // disabling stops background
    rd_chk(8'h6a, 8'h17);                   // halted once background off
    wr(8'h61, 8'h01);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    n_fail      = 0;
    check_count = 0;
    lin_cnt     = 0;
    os_cnt      = 0;
    clr_cnt     = 0;
    resetn_i    = 1'b0;
    ce_i        = 1'b1;
    address_i   = 10'h000;
    read_i      = 1'b0;
    write_i     = 1'b0;
    writedata_i = 32'h0000_0000;
    alarm_i     = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset();
    t_fg(8'h00, 16);
    t_fg(8'h11, 32);
    t_skip_irq();
    t_bg();
    test_done();
  end

  // Whole run needs a few hundred cycles; allow ample margin
  initial
  begin
    #(20 * 40000);
    n_fail++;
    test_done();
  end

endmodule

`default_nettype wire
